//--- verilog/strap_two_map.vh
// Contract
// - Config-complete pulses reset, latches strap values
// - Bit15 forced-100 link loss disables transmitter
// - Bit6 selects shortened parallel-detect link time
// - Fast/robust crossover mode forces bit6 set
// - Bit5 forces full duplex versus forced partner
// - Bit5 clear: standard duplex resolution
// - Bit4 lights LED only on 100 full-duplex
// - Bit3 isolates outputs on 100 half-duplex link
// - Bit2 set (default) detects idle symbol errors
// - Bit2 clear ignores idle symbol errors
// - Bit1 clear extends odd-nibble enable as error
// - Bit0 picks receive clock versus crystal reference
`ifndef STRAP_TWO_MAP_VH
`define STRAP_TWO_MAP_VH
`define SS1_OFFSET      5'h09
`define SS2_OFFSET      5'h0a
`define SS1_DONE_BIT    15
`define SS1_FASTX_BIT   6
`define SS1_ROBX_BIT    5
`define SS2_PEERDROP    15
`define SS2_FASTPD      6
`define SS2_EXTFD       5
`define SS2_LEDQ        4
`define SS2_ISO         3
`define SS2_IDLEERR     2
`define SS2_ODDDIS      1
`define SS2_RXCLK       0
`define SS1_RESET       16'h0000
`define SS2_RESET       16'h0104
`define SS2_WMASK       16'hffff
`endif

//--- verilog/phy_soft_strap_bank_two.v
`timescale 1ns/100ps
`default_nettype none
`include "strap_two_map.vh"
module phy_soft_strap_bank_two
(
    input  wire        sys_clk,
    input  wire        sys_rst,
    input  wire [4:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    output reg         strap_reset_pulse,
    input  wire        forced_100,
    input  wire        link_up,
    input  wire        link_100,
    input  wire        link_full,
    input  wire        partner_forced_100,
    input  wire        autoneg_or_forced_100,
    input  wire        rx_idle,
    input  wire        rx_symbol_err,
    input  wire        tx_en_in,
    input  wire        tx_odd_nibble,
    output reg         tx_disable,
    output reg         fast_parallel_detect,
    output reg         duplex_full,
    output reg         link_led,
    output reg         output_isolate,
    output reg         idle_symbol_error,
    output reg         tx_en_out,
    output reg         tx_err_out,
    output reg         rx_ref_is_rx_clk
);
    // Strap one is kept whole; only config-done and the crossover bits act in this block
    reg  [15:0] one_reg;
    reg  [15:0] one_next;
    reg  [15:0] two_reg;
    reg  [15:0] two_next;
    reg  [15:0] latched_reg;
    reg  [15:0] latched_next;
    reg         done_seen_reg;
    reg         done_seen_next;
    reg         pulse_next;
    reg  [15:0] rdata_next;
    reg         tx_disable_next;
    reg         fast_pd_next;
    reg         duplex_next;
    reg         led_next;
    reg         isolate_next;
    reg         idle_err_next;
    reg         tx_en_next;
    reg         tx_err_next;
    reg         rx_ref_next;

    wire        wr_one;
    wire        wr_two;
    wire        done_set;
    wire        fast_x_now;
    wire        fast_x_new;
    wire [15:0] fast_pd_mask;
    wire [15:0] two_view;
    wire [15:0] two_latch_view;
    wire        link_fast;
    wire        full_now;
    wire        odd_drop;

    assign wr_one         = reg_wr && (reg_addr == `SS1_OFFSET);
    assign wr_two         = reg_wr && (reg_addr == `SS2_OFFSET);
    assign done_set       = wr_one && reg_wdata[`SS1_DONE_BIT] && !done_seen_reg;
    assign fast_pd_mask   = 16'h0001 << `SS2_FASTPD;
    assign fast_x_now     = one_reg[`SS1_FASTX_BIT] | one_reg[`SS1_ROBX_BIT];
    // The done write may carry the crossover mode as well, so the latch looks at the
    // bus word; the strap-one copy only takes that word on the same edge
    assign fast_x_new     = reg_wdata[`SS1_FASTX_BIT] | reg_wdata[`SS1_ROBX_BIT];
    assign two_view       = fast_x_now ? (two_reg | fast_pd_mask) : two_reg;
    assign two_latch_view = fast_x_new ? (two_reg | fast_pd_mask) : two_reg;
    assign link_fast      = link_up && link_100;
    assign full_now       = (latched_reg[`SS2_EXTFD] && autoneg_or_forced_100
                             && partner_forced_100) ? 1'b1 : link_full;
    assign odd_drop       = !latched_reg[`SS2_ODDDIS] && tx_en_out && !tx_en_in
                            && tx_odd_nibble && !tx_err_out;

    // All sixteen bits of strap two are writable, reserved ones included
    always @*
    begin
        one_next = one_reg;
        two_next = two_reg;
        if (wr_one)
        begin
            one_next = reg_wdata;
        end
        if (wr_two)
        begin
            two_next = reg_wdata & `SS2_WMASK;
        end
    end

    // Config-complete is a one-shot per reset; later done writes neither pulse nor relatch
    always @*
    begin
        done_seen_next = done_seen_reg;
        latched_next   = latched_reg;
        pulse_next     = 1'b0;
        if (done_set)
        begin
            done_seen_next = 1'b1;
            latched_next   = two_latch_view;
            pulse_next     = 1'b1;
        end
    end

    // Read data stand for one cycle only and are zero otherwise
    always @*
    begin
        rdata_next = 16'h0000;
        if (reg_rd)
        begin
            case (reg_addr)
                `SS1_OFFSET: rdata_next = one_reg;
                `SS2_OFFSET: rdata_next = two_view;
                default:     rdata_next = 16'h0000;
            endcase
        end
    end

    // Datapath qualifiers act on the latched straps, never on the live register copy
    always @*
    begin
        tx_disable_next = latched_reg[`SS2_PEERDROP] && forced_100 && !link_up;
        fast_pd_next    = latched_reg[`SS2_FASTPD];
        duplex_next     = full_now;
        if (latched_reg[`SS2_LEDQ])
        begin
            led_next = link_fast && full_now;
        end
        else
        begin
            led_next = link_up;
        end
        isolate_next    = latched_reg[`SS2_ISO] && link_fast && !full_now;
        idle_err_next   = latched_reg[`SS2_IDLEERR] && rx_idle
                          && rx_symbol_err;
        rx_ref_next     = latched_reg[`SS2_RXCLK];
    end

    // Odd-nibble drop: hold the enable one more cycle and flag it as an error;
    // the error term in odd_drop stops a second stretch on the following cycle
    always @*
    begin
        tx_en_next  = tx_en_in;
        tx_err_next = 1'b0;
        if (odd_drop)
        begin
            tx_en_next  = 1'b1;
            tx_err_next = 1'b1;
        end
    end

    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            one_reg <= `SS1_RESET;
            two_reg <= `SS2_RESET;
        end
        else
        begin
            one_reg <= one_next;
            two_reg <= two_next;
        end
    end

    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            latched_reg       <= `SS2_RESET;
            done_seen_reg     <= 1'b0;
            strap_reset_pulse <= 1'b0;
        end
        else
        begin
            latched_reg       <= latched_next;
            done_seen_reg     <= done_seen_next;
            strap_reset_pulse <= pulse_next;
        end
    end

    // Kept apart so the read path can be retimed without touching the straps
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            reg_rdata <= 16'h0000;
        end
        else
        begin
            reg_rdata <= rdata_next;
        end
    end

    // Every qualifier leaves a flop, so the datapath never sees a glitch
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            tx_disable           <= 1'b0;
            fast_parallel_detect <= 1'b0;
            duplex_full          <= 1'b0;
            link_led             <= 1'b0;
            output_isolate       <= 1'b0;
            idle_symbol_error    <= 1'b0;
            tx_en_out            <= 1'b0;
            tx_err_out           <= 1'b0;
            rx_ref_is_rx_clk     <= 1'b0;
        end
        else
        begin
            tx_disable           <= tx_disable_next;
            fast_parallel_detect <= fast_pd_next;
            duplex_full          <= duplex_next;
            link_led             <= led_next;
            output_isolate       <= isolate_next;
            idle_symbol_error    <= idle_err_next;
            tx_en_out            <= tx_en_next;
            tx_err_out           <= tx_err_next;
            rx_ref_is_rx_clk     <= rx_ref_next;
        end
    end
endmodule // phy_soft_strap_bank_two
`default_nettype wire

//--- test/strap_two_sva.sv
`timescale 1ns/100ps
`default_nettype none
module strap_two_sva(input wire logic sys_clk,sys_rst,reg_wr,reg_rd,strap_reset_pulse,
    forced_100,link_up,link_100,link_full,partner_forced_100,autoneg_or_forced_100,rx_idle,
    rx_symbol_err,tx_en_in,tx_odd_nibble,tx_disable,fast_parallel_detect,duplex_full,link_led,
    output_isolate,idle_symbol_error,tx_en_out,tx_err_out,rx_ref_is_rx_clk,
    input wire logic [4:0] reg_addr,input wire logic [15:0] reg_wdata,reg_rdata);
default clocking @(posedge sys_clk); endclocking
default disable iff (sys_rst);
a_pulse_cause: assert property
    (strap_reset_pulse |-> $past(reg_wr&&reg_addr==5'h09&&reg_wdata[15])) else $error("pulse");
a_idle_gate: assert property
    (idle_symbol_error |-> $past(rx_idle&&rx_symbol_err)) else $error("idle error");
a_isolate_link: assert property
    (output_isolate |-> $past(link_up&&link_100)) else $error("isolate");
a_led_link: assert property (link_led |-> $past(link_up)) else $error("led");
a_drop_cause: assert property
    (tx_disable |-> $past(forced_100&&!link_up)) else $error("tx disable");
a_duplex_std: assert property
    (link_full && !sys_rst |=> duplex_full) else $error("duplex");
a_duplex_cause: assert property
    (duplex_full |-> $past(link_full||autoneg_or_forced_100&&partner_forced_100)) else $error("fd");
a_err_extend: assert property
    (tx_err_out |-> tx_en_out&&!$past(tx_en_in)) else $error("odd nibble");
c_pulse: cover property (strap_reset_pulse);
c_isolate: cover property (output_isolate);
c_err: cover property (tx_err_out);
endmodule // strap_two_sva
bind phy_soft_strap_bank_two strap_two_sva sva_u(.*);
`default_nettype wire

//--- test/tb_phy_soft_strap_bank_two.sv
`timescale 1ns/100ps
`default_nettype none
module tb_phy_soft_strap_bank_two;
logic sys_clk=0,sys_rst=1,reg_wr=0,reg_rd=0;
logic [4:0] reg_addr=0;
logic [15:0] reg_wdata=0,reg_rdata,s2,s1,v;
logic [9:0] din=0;
logic [31:0] rs=32'h18271586;
logic ete,etr,odd;
wire [6:0] o;
wire p,te,tr;
int bad_count=0,comparisons=0;
phy_soft_strap_bank_two dut_u(.sys_clk,.sys_rst,.reg_addr,.reg_wdata,.reg_wr,.reg_rd,.reg_rdata,
    .strap_reset_pulse(p),.forced_100(din[0]),.link_up(din[1]),.link_100(din[2]),
    .link_full(din[3]),.partner_forced_100(din[4]),.autoneg_or_forced_100(din[5]),
    .rx_idle(din[6]),.rx_symbol_err(din[7]),.tx_en_in(din[8]),.tx_odd_nibble(din[9]),
    .tx_disable(o[0]),.fast_parallel_detect(o[1]),.duplex_full(o[2]),.link_led(o[3]),
    .output_isolate(o[4]),.idle_symbol_error(o[5]),.tx_en_out(te),.tx_err_out(tr),
    .rx_ref_is_rx_clk(o[6]));
function automatic logic [31:0] xs(input logic [31:0] x);
    x^=x<<13; x^=x>>17; return x^(x<<5);
endfunction
function automatic logic [6:0] ex(input logic [15:0] s,input logic [9:0] d);
    logic fd;
    fd=s[5]&d[5]&d[4]|d[3];
    return {s[0],s[2]&d[6]&d[7],s[3]&d[1]&d[2]&!fd,s[4]?d[1]&d[2]&fd:d[1],fd,s[6],s[15]&d[0]&!d[1]};
endfunction
task chk(input string n,input logic [15:0] s,e);
    comparisons++;
    if(s!==e) begin bad_count++; $display("unexpected %s exp %h seen %h",n,e,s); end
endtask
// Strobes drop at the edge, the extra 1 ns keeps the next task off that time step
task wr(input logic [4:0] a,input logic [15:0] d);
    reg_addr<=a; reg_wdata<=d; reg_wr<=1; @(posedge sys_clk); reg_wr<=0; #1;
endtask
task rd(input logic [4:0] a,output logic [15:0] d);
    reg_addr<=a; reg_rd<=1; @(posedge sys_clk); reg_rd<=0; #1 d=reg_rdata;
endtask
task test_done;
    $display("comparisons %0d mismatches %0d",comparisons,bad_count);
    if(bad_count==0&&comparisons>0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
initial forever #5 sys_clk=~sys_clk;
initial
begin
    for(int k=0;k<4;k++)
    begin
        sys_rst<=1; repeat(5) @(posedge sys_clk); sys_rst<=0;
        rd(5'h0a,v); chk("reset",v,16'h0104);
        rd(5'h1f,v); chk("unmapped",v,16'h0000);
        rs=xs(rs); s1={1'b1,8'h00,rs[22:21],5'h00};
        s2={rs[15],1'b0,7'h02,rs[6:0]};
        wr(5'h0a,s2); wr(5'h09,s1); chk("pulse",p,1);
        s2[6]=s2[6]|s1[6]|s1[5]; wr(5'h09,s1); chk("once",p,0);
        rd(5'h0a,v); chk("readback",v,s2);
        // Inputs have stood still for several cycles, so the enable pipe has settled
        ete=din[8]; etr=0;
        repeat(30)
        begin
            rs=xs(rs); din<=rs[9:0]; @(posedge sys_clk);
            #1 chk("outputs",o,ex(s2,din));
            odd=!s2[1]&&ete&&!din[8]&&din[9]&&!etr; ete=odd|din[8]; etr=odd;
            chk("tx enable",te,ete);
            chk("tx error",tr,etr);
        end
    end
    test_done;
end
endmodule // tb_phy_soft_strap_bank_two
`default_nettype wire
